// *** rtl/gpic_pkg.sv ***
/*
 Constants of the grouped priority interrupt controller: register indices,
 field positions, reset values, source and flag tables, vector table.
 Assumes register byte addresses are four times the indices below.
*/
package gpic_pkg;

  localparam int NUM_SRC = 15;
  localparam int NUM_GROUPS = 6;
  localparam int NUM_LEVELS = 4;
  localparam int NUM_FLAGS = 18;

  // Register indices
  localparam logic [7:0] IDX_ENABLE_MAIN = 8'ha8;
  localparam logic [7:0] IDX_ENABLE_AUX = 8'hb8;
  localparam logic [7:0] IDX_ENABLE_ANALOG = 8'h9a;
  localparam logic [7:0] IDX_PWM_CTRL = 8'hd1;
  localparam logic [7:0] IDX_T2_FLAGS = 8'hc0;
  localparam logic [7:0] IDX_ANALOG_FLAGS = 8'h97;
  localparam logic [7:0] IDX_TIMER01 = 8'h88;
  localparam logic [7:0] IDX_UART = 8'h98;
  localparam logic [7:0] IDX_SPI = 8'he1;
  localparam logic [7:0] IDX_TWI = 8'hdc;
  localparam logic [7:0] IDX_PRIO_LOW = 8'ha9;
  localparam logic [7:0] IDX_PRIO_HIGH = 8'hb9;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hf8;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hf9;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Writable bits per register
  localparam logic [7:0] MAIN_WMASK = 8'hbf;
  localparam logic [7:0] AUX_WMASK = 8'hbf;
  localparam logic [7:0] ANALOG_WMASK = 8'h06;
  localparam logic [7:0] PRIO_WMASK = 8'h3f;
  localparam logic [7:0] STATUS_WMASK = 8'h07;

  // Enable field positions
  localparam int EN_MASTER_BIT = 7;
  localparam int EN_T2_BIT = 5;
  localparam int EN_UART_BIT = 4;
  localparam int EN_T1_BIT = 3;
  localparam int EN_EXTB_BIT = 2;
  localparam int EN_T0_BIT = 1;
  localparam int EN_EXTA_BIT = 0;
  localparam int EN_T2RL_BIT = 7;
  localparam int EN_C3_BIT = 5;
  localparam int EN_C2_BIT = 4;
  localparam int EN_C1_BIT = 3;
  localparam int EN_C0_BIT = 2;
  localparam int EN_SPI_BIT = 1;
  localparam int EN_TWI_BIT = 0;
  localparam int EN_CMP_BIT = 2;
  localparam int EN_ADC_BIT = 1;
  localparam int EN_PWM_BIT = 7;

  // Controller status bits
  localparam int ST_ACCEPT_BIT = 0;
  localparam int ST_PREEMPT_BIT = 1;
  localparam int ST_SPURIOUS_BIT = 2;

  // Flag indices
  localparam int F_EXTA = 0;
  localparam int F_EXTB = 1;
  localparam int F_T0 = 2;
  localparam int F_T1 = 3;
  localparam int F_C0 = 4;
  localparam int F_C1 = 5;
  localparam int F_C2 = 6;
  localparam int F_C3 = 7;
  localparam int F_PWM = 8;
  localparam int F_TWI = 9;
  localparam int F_ADC = 10;
  localparam int F_SPID = 11;
  localparam int F_SPIM = 12;
  localparam int F_CMP = 13;
  localparam int F_UTX = 14;
  localparam int F_URX = 15;
  localparam int F_T2 = 16;
  localparam int F_T2RL = 17;

  // Home register and bit of each flag, by flag index
  localparam logic [7:0] FLAG_REG [NUM_FLAGS] = '{
    IDX_TIMER01, IDX_TIMER01, IDX_TIMER01, IDX_TIMER01,
    IDX_T2_FLAGS, IDX_T2_FLAGS, IDX_T2_FLAGS, IDX_T2_FLAGS,
    IDX_PWM_CTRL, IDX_TWI, IDX_ANALOG_FLAGS, IDX_SPI, IDX_SPI,
    IDX_ANALOG_FLAGS, IDX_UART, IDX_UART, IDX_T2_FLAGS, IDX_T2_FLAGS};
  localparam logic [2:0] FLAG_BIT [NUM_FLAGS] = '{
    3'h1, 3'h3, 3'h5, 3'h7, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3,
    3'h3, 3'h0, 3'h7, 3'h4, 3'h1, 3'h1, 3'h0, 3'h6, 3'h7};

  // Source indices in natural priority order, highest first
  localparam int S_EXTA = 0;
  localparam int S_PWM = 1;
  localparam int S_TWI = 2;
  localparam int S_T0 = 3;
  localparam int S_ADC = 4;
  localparam int S_SPI = 5;
  localparam int S_EXTB = 6;
  localparam int S_CMP = 7;
  localparam int S_C0 = 8;
  localparam int S_T1 = 9;
  localparam int S_C1 = 10;
  localparam int S_UART = 11;
  localparam int S_C2 = 12;
  localparam int S_T2 = 13;
  localparam int S_C3 = 14;

  localparam logic [15:0] SRC_VECTOR [NUM_SRC] = '{
    16'h0003, 16'h0083, 16'h0043, 16'h000b, 16'h008b,
    16'h004b, 16'h0013, 16'h0093, 16'h0053, 16'h001b,
    16'h005b, 16'h0023, 16'h0063, 16'h002b, 16'h006b};
  localparam logic [2:0] SRC_GROUP [NUM_SRC] = '{
    3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2,
    3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
  // Flag cleared on acceptance, and which sources clear by hardware
  localparam logic [4:0] SRC_FLAG [NUM_SRC] = '{
    5'h00, 5'h08, 5'h09, 5'h02, 5'h0a, 5'h0b, 5'h01, 5'h0d,
    5'h04, 5'h03, 5'h05, 5'h0e, 5'h06, 5'h10, 5'h07};
  localparam logic [NUM_SRC-1:0] SRC_HWCLR = 15'h5749;

  typedef enum logic [1:0] {
    GPIC_IDLE = 2'b00,
    GPIC_OFFER = 2'b01,
    GPIC_TAKEN = 2'b11
  } gpic_state_e;

endpackage : gpic_pkg

// *** rtl/gpic_flag_cell.sv ***
/*
 One interrupt request flag: set by its event, cleared by hardware on
 acceptance, written by software. Assumes one clock and async reset.
*/
`timescale 1ns/1ps
`default_nettype none

module gpic_flag_cell (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_evt,
  input wire logic hw_clr,
  input wire logic sw_we,
  input wire logic sw_val,
  output logic flag
);

  logic flag_r;

  // Event beats any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_r <= 1'b0;
    else if (set_evt)
      flag_r <= 1'b1;
    else if (hw_clr)
      flag_r <= 1'b0;
    else if (sw_we)
      flag_r <= sw_val;
  end

  assign flag = flag_r;

endmodule : gpic_flag_cell

`default_nettype wire

// *** rtl/gpic_top.sv ***
/*
 Grouped priority interrupt controller with APB register access and a
 request/acknowledge/return handshake towards the CPU core.
 Assumes event pulses and CPU strobes are synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module gpic_top #(
  parameter int AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gpic_pkg::NUM_FLAGS-1:0] flag_set_events,
  input wire logic irq_ack,
  input wire logic return_from_interrupt,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic irq
);
  import gpic_pkg::*;
  logic [7:0] en_main_r, en_aux_r, en_analog_r, prio_low_r, prio_high_r;
  logic [7:0] status_r, mask_r, idx, rd_val, wbyte, status_nxt;
  logic pwm_en_r, pready_r, pslverr_r, irq_req_r, irq_r;
  logic [31:0] prdata_r;
  logic [15:0] vector_r;
  gpic_state_e state_r;
  logic [3:0] acc_src_r, best_src;
  logic [1:0] acc_lv_r, best_lv, cur_lv;
  logic [NUM_LEVELS-1:0] active_r, active_nxt;
  logic [NUM_FLAGS-1:0] flags, hw_clr, sw_we, sw_val;
  logic [NUM_SRC-1:0] src_req;
  logic [1:0] src_lv [NUM_SRC];
  logic found, has_active, allow, accept, in_range, hit, access, wr;
  // Request flags
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++)
    begin : gen_flag
      gpic_flag_cell u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(flag_set_events[g]),
        .hw_clr(hw_clr[g]),
        .sw_we(sw_we[g]),
        .sw_val(sw_val[g]),
        .flag(flags[g])
      );
    end
  endgenerate

  // Per-source request
  always_comb
  begin
    src_req = '0;
    src_req[S_EXTA] = flags[F_EXTA] & en_main_r[EN_EXTA_BIT];
    src_req[S_PWM] = flags[F_PWM] & pwm_en_r;
    src_req[S_TWI] = flags[F_TWI] & en_aux_r[EN_TWI_BIT];
    src_req[S_T0] = flags[F_T0] & en_main_r[EN_T0_BIT];
    src_req[S_ADC] = flags[F_ADC] & en_analog_r[EN_ADC_BIT];
    src_req[S_SPI] = (flags[F_SPID] | flags[F_SPIM])
                     & en_aux_r[EN_SPI_BIT];
    src_req[S_EXTB] = flags[F_EXTB] & en_main_r[EN_EXTB_BIT];
    src_req[S_CMP] = flags[F_CMP] & en_analog_r[EN_CMP_BIT];
    src_req[S_C0] = flags[F_C0] & en_aux_r[EN_C0_BIT];
    src_req[S_T1] = flags[F_T1] & en_main_r[EN_T1_BIT];
    src_req[S_C1] = flags[F_C1] & en_aux_r[EN_C1_BIT];
    src_req[S_UART] = (flags[F_UTX] | flags[F_URX])
                      & en_main_r[EN_UART_BIT];
    src_req[S_C2] = flags[F_C2] & en_aux_r[EN_C2_BIT];
    src_req[S_T2] = (flags[F_T2] & en_main_r[EN_T2_BIT])
                    | (flags[F_T2RL] & en_aux_r[EN_T2RL_BIT]);
    src_req[S_C3] = flags[F_C3] & en_aux_r[EN_C3_BIT];
    if (!en_main_r[EN_MASTER_BIT])
      src_req = '0;
  end

  // Group level of each source
  always_comb
  begin
    for (int i = 0; i < NUM_SRC; i++)
      src_lv[i] = {prio_high_r[SRC_GROUP[i]],
                   prio_low_r[SRC_GROUP[i]]};
  end

  // Highest level wins; strict compare keeps natural order on ties
  always_comb
  begin
    found = 1'b0;
    best_lv = 2'b00;
    best_src = 4'h0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (src_req[i] && (!found || src_lv[i] > best_lv))
      begin
        found = 1'b1;
        best_lv = src_lv[i];
        best_src = 4'(i);
      end
    end
  end

  // Level of the running routine
  always_comb
  begin
    has_active = |active_r;
    cur_lv = 2'b00;
    for (int l = 0; l < NUM_LEVELS; l++)
    begin
      if (active_r[l])
        cur_lv = 2'(l);
    end
  end

  assign allow = found && (!has_active || best_lv > cur_lv);
  assign accept = irq_ack && (state_r == GPIC_OFFER);
  // Offer state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= GPIC_IDLE;
      irq_req_r <= 1'b0;
      vector_r <= RESET_VECTOR;
      acc_src_r <= 4'h0;
      acc_lv_r <= 2'b00;
    end
    else
    begin
      case (state_r)
        GPIC_IDLE:
        begin
          if (allow)
          begin
            state_r <= GPIC_OFFER;
            irq_req_r <= 1'b1;
            vector_r <= SRC_VECTOR[best_src];
            acc_src_r <= best_src;
            acc_lv_r <= best_lv;
          end
        end
        GPIC_OFFER:
        begin
          if (accept || !allow)
          begin
            state_r <= accept ? GPIC_TAKEN : GPIC_IDLE;
            irq_req_r <= 1'b0;
          end
          else
          begin
            vector_r <= SRC_VECTOR[best_src];
            acc_src_r <= best_src;
            acc_lv_r <= best_lv;
          end
        end
        default:
        begin
          state_r <= GPIC_IDLE;
          irq_req_r <= 1'b0;
        end
      endcase
    end
  end

  // Hardware clear of the accepted source's flag
  always_comb
  begin
    hw_clr = '0;
    if (accept && SRC_HWCLR[acc_src_r])
      hw_clr[SRC_FLAG[acc_src_r]] = 1'b1;
  end
  // In-service levels: return drops the top, acceptance adds one
  always_comb
  begin
    active_nxt = active_r;
    if (return_from_interrupt && has_active)
      active_nxt[cur_lv] = 1'b0;
    if (accept)
      active_nxt[acc_lv_r] = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_r <= '0;
    else
      active_r <= active_nxt;
  end

  // APB decode
  assign idx = paddr[9:2];
  assign in_range = (paddr[AW-1:10] == '0) && (paddr[1:0] == 2'b00);
  assign access = psel && penable;
  assign wbyte = pwdata[7:0];
  assign wr = access && pready_r && pwrite && hit && pstrb[0];

  always_comb
  begin
    rd_val = 8'h00;
    hit = 1'b1;
    if (idx == IDX_ENABLE_MAIN)
      rd_val = en_main_r;
    else if (idx == IDX_ENABLE_AUX)
      rd_val = en_aux_r;
    else if (idx == IDX_ENABLE_ANALOG)
      rd_val = en_analog_r;
    else if (idx == IDX_PRIO_LOW)
      rd_val = prio_low_r;
    else if (idx == IDX_PRIO_HIGH)
      rd_val = prio_high_r;
    else if (idx == IDX_IRQ_STATUS)
      rd_val = status_r;
    else if (idx == IDX_IRQ_MASK)
      rd_val = mask_r;
    else if (idx == IDX_PWM_CTRL)
      rd_val[EN_PWM_BIT] = pwm_en_r;
    else if (idx == IDX_T2_FLAGS || idx == IDX_ANALOG_FLAGS ||
             idx == IDX_TIMER01 || idx == IDX_UART ||
             idx == IDX_SPI || idx == IDX_TWI)
      rd_val = 8'h00;
    else
      hit = 1'b0;
    for (int f = 0; f < NUM_FLAGS; f++)
    begin
      if (idx == FLAG_REG[f])
        rd_val[FLAG_BIT[f]] = flags[f];
    end
    if (!in_range)
      hit = 1'b0;
  end

  // Software access to flags in their home registers
  always_comb
  begin
    for (int f = 0; f < NUM_FLAGS; f++)
    begin
      sw_we[f] = wr && (idx == FLAG_REG[f]);
      sw_val[f] = wbyte[FLAG_BIT[f]];
    end
  end

  // One wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= access && !pready_r;
      pslverr_r <= access && !pready_r && !hit;
      if (access && !pready_r && !pwrite)
        prdata_r <= {24'h000000, hit ? rd_val : 8'h00};
    end
  end

  // Enable registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_main_r <= REG_RESET;
      en_aux_r <= REG_RESET;
      en_analog_r <= REG_RESET;
      pwm_en_r <= 1'b0;
    end
    else if (wr)
    begin
      if (idx == IDX_ENABLE_MAIN)
        en_main_r <= wbyte & MAIN_WMASK;
      else if (idx == IDX_ENABLE_AUX)
        en_aux_r <= wbyte & AUX_WMASK;
      else if (idx == IDX_ENABLE_ANALOG)
        en_analog_r <= wbyte & ANALOG_WMASK;
      else if (idx == IDX_PWM_CTRL)
        pwm_en_r <= wbyte[EN_PWM_BIT];
    end
  end

  // Group level registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prio_low_r <= REG_RESET;
      prio_high_r <= REG_RESET;
    end
    else if (wr)
    begin
      if (idx == IDX_PRIO_LOW)
        prio_low_r <= wbyte & PRIO_WMASK;
      else if (idx == IDX_PRIO_HIGH)
        prio_high_r <= wbyte & PRIO_WMASK;
    end
  end

  // Controller status: write one to clear, new event wins
  always_comb
  begin
    status_nxt = status_r;
    if (wr && idx == IDX_IRQ_STATUS)
      status_nxt = status_r & ~(wbyte & STATUS_WMASK);
    if (accept)
      status_nxt[ST_ACCEPT_BIT] = 1'b1;
    if (accept && has_active)
      status_nxt[ST_PREEMPT_BIT] = 1'b1;
    if (return_from_interrupt && !has_active)
      status_nxt[ST_SPURIOUS_BIT] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= REG_RESET;
      mask_r <= REG_RESET;
      irq_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      if (wr && idx == IDX_IRQ_MASK)
        mask_r <= wbyte & STATUS_WMASK;
      irq_r <= |(status_r & mask_r);
    end
  end
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_req = irq_req_r;
  assign irq_vector = vector_r;
  assign irq = irq_r;
endmodule : gpic_top

`default_nettype wire

// *** tb/gpic_top_monitor.sv ***
/*
 Port checker for gpic_top, bound to every instance of it.
 Assumes one pclk domain and an asynchronous active-low presetn.
*/
`timescale 1ns/1ps
`default_nettype none

module gpic_top_monitor #(
  parameter int AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [gpic_pkg::NUM_FLAGS-1:0] flag_set_events,
  input wire logic irq_ack,
  input wire logic return_from_interrupt,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic irq
);
  import gpic_pkg::*;
  logic seen_r;
  logic [7:0] idx;
  logic rd_ok;
  assign idx = paddr[9:2];
  assign rd_ok = pready && !pwrite && !pslverr;

  // Remembers the first offer since reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seen_r <= 1'b0;
    else if (irq_req)
      seen_r <= 1'b1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_vec_legal; irq_req |-> irq_vector inside {16'h0003, 16'h000b,
    16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0043, 16'h004b, 16'h0053,
    16'h005b, 16'h0063, 16'h006b, 16'h0083, 16'h008b, 16'h0093}; endproperty
  a_vec_legal: assert property (p_vec_legal) else $error("bad vector");
  property p_reset_vec; !seen_r && !irq_req |-> irq_vector == 16'h0000;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("vector");
  property p_ack_drop; irq_req && irq_ack |=> !irq_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("req held");
  property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("ready timing");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready width");
  property p_unmapped; pready && idx == 8'h00 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_err0; pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err0: assert property (p_err0) else $error("error read");
  property p_prio_rd; rd_ok && (idx == IDX_PRIO_LOW || idx == IDX_PRIO_HIGH)
    |-> prdata[31:6] == 26'h0; endproperty
  a_prio_rd: assert property (p_prio_rd) else $error("prio bits");
  property p_main_rd; rd_ok && idx == IDX_ENABLE_MAIN
    |-> prdata[31:8] == 24'h0 && !prdata[6]; endproperty
  a_main_rd: assert property (p_main_rd) else $error("main bits");
  property p_ana_rd; rd_ok && idx == IDX_ENABLE_ANALOG
    |-> (prdata & ~32'h6) == 32'h0; endproperty
  a_ana_rd: assert property (p_ana_rd) else $error("analog bits");

  c_ack: cover property (irq_req && irq_ack);
  c_err: cover property (pready && pslverr);
  c_ret: cover property (return_from_interrupt && irq_req);
endmodule : gpic_top_monitor

bind gpic_top gpic_top_monitor #(.AW(AW)) i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flag_set_events(flag_set_events), .irq_ack(irq_ack),
  .return_from_interrupt(return_from_interrupt), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq(irq));

`default_nettype wire

// *** tb/gpic_cpu_model.sv ***
/*
 CPU core model: takes an offered vector, issues returns on command.
 Assumes the bench raises ack_en per take and pulses ret_cmd.
*/
`timescale 1ns/1ps
`default_nettype none

module gpic_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  input wire logic ret_cmd,
  output logic irq_ack,
  output logic return_from_interrupt,
  output logic taken,
  output logic [15:0] taken_vec
);
  logic [3:0] wait_r;

  // Ack after ack_delay cycles; vector taken at the ack edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ack <= 1'b0;
      taken <= 1'b0;
      taken_vec <= 16'h0000;
      wait_r <= 4'h0;
    end
    else
    begin
      taken <= irq_ack && irq_req;
      if (irq_ack && irq_req)
        taken_vec <= irq_vector;
      irq_ack <= 1'b0;
      if (!irq_req || !ack_en || irq_ack || taken)
        wait_r <= 4'h0;
      else if (wait_r >= ack_delay)
        irq_ack <= 1'b1;
      else
        wait_r <= wait_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      return_from_interrupt <= 1'b0;
    else
      return_from_interrupt <= ret_cmd;
  end
endmodule : gpic_cpu_model

`default_nettype wire

// *** tb/tb.sv ***
/*
 Bench for gpic_top: APB tasks, CPU model, event pulses.
 Assumes gpic_cpu_model acks on ack_en and returns on ret_cmd.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import gpic_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [NUM_FLAGS-1:0] flag_set_events = '0;
  logic ack_en = 1'b0;
  logic ret_cmd = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq_ack, return_from_interrupt;
  logic irq_req, irq, taken;
  logic [15:0] irq_vector, taken_vec;
  int errors = 0;
  int checks_done = 0;
  localparam logic [15:0] VEC [15] = '{16'h0003, 16'h0083, 16'h0043,
    16'h000b, 16'h008b, 16'h004b, 16'h0013, 16'h0093, 16'h0053,
    16'h001b, 16'h005b, 16'h0023, 16'h0063, 16'h002b, 16'h006b};
  localparam logic [14:0] HW_CLR = 15'h5749;

  gpic_top #(.AW(12)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flag_set_events(flag_set_events), .irq_ack(irq_ack),
    .return_from_interrupt(return_from_interrupt), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq(irq));
  gpic_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .irq_vector(irq_vector), .ack_en(ack_en), .ack_delay(ack_delay),
    .ret_cmd(ret_cmd), .irq_ack(irq_ack),
    .return_from_interrupt(return_from_interrupt), .taken(taken),
    .taken_vec(taken_vec));

  initial
  begin
    forever #20 pclk = ~pclk;
  end

  task close_out;
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  task tmo(input int n, input int lim);
    if (n >= lim)
    begin
      errors++;
      close_out();
    end
  endtask : tmo

  task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tmo(n, 20);
  endtask : apb

  task rdc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    cmp(rd, {24'h0, e});
  endtask : rdc

  task pulse(input logic [NUM_FLAGS-1:0] m);
    @(posedge pclk);
    flag_set_events <= m;
    @(posedge pclk);
    flag_set_events <= '0;
  endtask : pulse

  task take(input logic [15:0] e);
    int n;
    @(posedge pclk);
    ack_en <= 1'b1;
    n = 0;
    while (taken !== 1'b1 && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    ack_en <= 1'b0;
    tmo(n, 60);
    cmp({16'h0, taken_vec}, {16'h0, e});
  endtask : take

  task ret;
    @(posedge pclk);
    ret_cmd <= 1'b1;
    @(posedge pclk);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : ret

  task idle;
    repeat (4) @(posedge pclk);
    cmp(32'(irq_req), 32'h0);
  endtask : idle

  task t_regs;
    rdc(IDX_PRIO_LOW, 8'h00);
    rdc(IDX_PRIO_HIGH, 8'h00);
    rdc(IDX_ENABLE_MAIN, 8'h00);
    apb(1'b1, IDX_PRIO_HIGH, 8'hff);
    rdc(IDX_PRIO_HIGH, 8'h3f);
    apb(1'b1, IDX_PRIO_HIGH, 8'h00);
    apb(1'b1, 8'h00, 8'hff);
    cmp(32'(err), 32'h1);
    pulse(18'h1 << F_ADC);
    rdc(IDX_ANALOG_FLAGS, 8'h01);
    apb(1'b1, IDX_ENABLE_ANALOG, 8'h06);
    idle();
    apb(1'b1, IDX_ENABLE_MAIN, 8'h80);
    take(16'h008b);
    apb(1'b1, IDX_ANALOG_FLAGS, 8'h00);
    ret();
    apb(1'b1, IDX_ENABLE_MAIN, 8'hbf);
    apb(1'b1, IDX_ENABLE_AUX, 8'hbf);
    apb(1'b1, IDX_PWM_CTRL, 8'h80);
  endtask : t_regs

  task t_vectors;
    int f;
    logic [7:0] r;
    for (int s = 0; s < NUM_SRC; s++)
    begin
      f = SRC_FLAG[s];
      r = FLAG_REG[f];
      ack_delay <= 4'(s % 3);
      pulse(18'h1 << f);
      take(VEC[s]);
      apb(1'b0, r, 8'h00);
      cmp(32'(rd[FLAG_BIT[f]]), 32'(!HW_CLR[s]));
      if (!HW_CLR[s])
        apb(1'b1, r, (r == IDX_PWM_CTRL) ? 8'h80 : 8'h00);
      ret();
    end
  endtask : t_vectors

  task t_tie;
    pulse((18'h1 << F_PWM) | (18'h1 << F_EXTB) | (18'h1 << F_SPIM));
    take(16'h0083);
    apb(1'b1, IDX_PWM_CTRL, 8'h80);
    ret();
    take(16'h004b);
    apb(1'b1, IDX_SPI, 8'h00);
    ret();
    take(16'h0013);
    ret();
    pulse((18'h1 << F_URX) | (18'h1 << F_T2RL));
    take(16'h0023);
    apb(1'b1, IDX_UART, 8'h00);
    ret();
    take(16'h002b);
    apb(1'b1, IDX_T2_FLAGS, 8'h00);
    ret();
  endtask : t_tie

  task t_prio;
    apb(1'b1, IDX_PRIO_HIGH, 8'h02);
    apb(1'b1, IDX_PRIO_LOW, 8'h08);
    pulse((18'h1 << F_EXTA) | (18'h1 << F_T1) | (18'h1 << F_ADC));
    take(16'h008b);
    pulse(18'h1 << F_SPID);
    idle();
    apb(1'b1, IDX_ANALOG_FLAGS, 8'h00);
    ret();
    take(16'h004b);
    apb(1'b1, IDX_SPI, 8'h00);
    ret();
    take(16'h001b);
    ret();
    take(16'h0003);
    pulse(18'h1 << F_T0);
    take(16'h000b);
    ret();
    ret();
    apb(1'b1, IDX_PRIO_HIGH, 8'h00);
    apb(1'b1, IDX_PRIO_LOW, 8'h00);
  endtask : t_prio

  task t_irq;
    ret();
    rdc(IDX_IRQ_STATUS, 8'h07);
    cmp(32'(irq), 32'h0);
    apb(1'b1, IDX_IRQ_MASK, 8'h04);
    repeat (2) @(posedge pclk);
    cmp(32'(irq), 32'h1);
    apb(1'b1, IDX_IRQ_STATUS, 8'h07);
    rdc(IDX_IRQ_STATUS, 8'h00);
    cmp(32'(irq), 32'h0);
  endtask : t_irq

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_vectors();
    t_tie();
    t_prio();
    t_irq();
    close_out();
  end
endmodule : tb

`default_nettype wire
